// ===== verilog/aosr_pkg.sv
// Package of constants and types for the output and status registers.
package aosr_pkg;
   // ----------------------------------------------------------------
   // Register indices; byte address is four times the index
   // ----------------------------------------------------------------
   localparam logic [5:0] IDX_Z_LOW = 6'h1a;
   localparam logic [5:0] IDX_TEMP_HIGH = 6'h1b;
   localparam logic [5:0] IDX_TEMP_LOW_TRIM = 6'h1c;
   localparam logic [5:0] IDX_QUEUE_PORT = 6'h1d;
   localparam logic [5:0] IDX_COUNT_LOW = 6'h1e;
   localparam logic [5:0] IDX_COUNT_HIGH = 6'h1f;
   localparam logic [5:0] IDX_MISC_ZERO = 6'h20;
   localparam logic [5:0] IDX_OPERATING_MODE_REGISTER = 6'h26;
   localparam logic [5:0] IDX_TEMP_CFG = 6'h30;
   localparam logic [5:0] IDX_PARITY_CFG = 6'h31;
   localparam logic [5:0] IDX_INT_STATUS = 6'h32;
   localparam logic [5:0] IDX_INT_MASK = 6'h33;
   // ----------------------------------------------------------------
   // Field positions and reset values
   // ----------------------------------------------------------------
   localparam int OPM_PDM_BIT = 5;
   localparam int MISC_VARIANT_BIT = 7;
   localparam int MISC_CHECK_BIT = 6;
   localparam int MISC_ERR_BIT = 5;
   localparam int INT_PARITY_BIT = 0;
   localparam int INT_OVERFLOW_BIT = 1;
   localparam int TRIM_SHIFT = 7;
   localparam logic [7:0] RESET_BYTE = 8'h00;
   // ----------------------------------------------------------------
   // Operating mode codes
   // ----------------------------------------------------------------
   localparam logic [3:0] MODE_HEART_SOUND = 4'h1;
   localparam logic [3:0] MODE_ULTRA_LOW_POWER = 4'h2;
   localparam logic [3:0] MODE_VERY_LOW_POWER = 4'h3;
   localparam logic [3:0] MODE_LOW_POWER = 4'h8;
   localparam logic [3:0] MODE_REDUCED_BW = 4'ha;
   localparam logic [3:0] MODE_HIGH_PERF = 4'hc;
   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_HZ = 20000000;
   localparam int PARITY_PERIOD_US = 1000;
   localparam int PARITY_PERIOD_CYCLES = PARITY_PERIOD_US * (CLK_HZ / 1000000);
   // ----------------------------------------------------------------
   // Bus answer phase
   // ----------------------------------------------------------------
   typedef enum logic [0:0] {
      BUS_IDLE = 1'b0,
      BUS_DONE = 1'b1
   } aosr_bus_t;
   // Whole state of the block except the sample memory.
   typedef struct packed {
      aosr_bus_t bus;
      logic [31:0] prdata;
      logic pslverr;
      logic irq;
      logic [7:0] z_low;
      logic [11:0] temp;
      logic [3:0] x_trim;
      logic [4:0] gain_xy;
      logic variant;
      logic [7:0] operating_mode_register;
      logic [7:0] temp_cfg;
      logic [7:0] par_cfg;
      logic par_check_flag;
      logic par_err_flag;
      logic [1:0] int_stat;
      logic [1:0] int_mask;
      logic [8:0] count;
      logic [8:0] rd_ptr;
      logic [8:0] wr_ptr;
      logic byte_sel;
      logic [15:0] timer;
      logic [15:0] x_out;
      logic temp_high_gain;
   } aosr_state_t;
endpackage : aosr_pkg

// ===== verilog/aosr_regs.sv
// Output, status and queue read registers of the accelerometer, on APB.
// How it works
// - Z low result byte is captured from the range-scaled front end.
// - Twelve-bit modes force the low nibble of the Z low byte to zero.
// - Temperature gain select bit picks 10.2 or 16.5 counts per degree.
// - Register after temperature high: temperature low nibble, X trim.
// - Low-noise modes add X times trim, shifted right seven, to X.
// - Bitstream output enabled: X passes without trim correction.
// - Queue port returns sixteen-bit signed samples through one byte.
// - Nine-bit entry count split over two status registers.
// - Parity mismatch sets a sticky flag cleared by reset or any write to a mapped register.
// - With parity checking enabled, checks start at a fixed interval.
// - Five-bit X/Y gain scaler field, value four means unity gain.
// - Top bit of misc status shows the sensor variant.
// - Operating mode bit five enables the bitstream output.
//
// Chosen here: register access over APB.
`timescale 1ns/100ps
module aosr_regs #(
   parameter int DEPTH = 320,
   parameter int PARITY_CYCLES = aosr_pkg::PARITY_PERIOD_CYCLES
) (
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic irq,
   input wire logic z_valid,
   input wire logic [15:0] z_sample,
   input wire logic temp_valid,
   input wire logic [11:0] temp_sample,
   input wire logic x_valid,
   input wire logic [15:0] x_sample,
   output logic [15:0] x_corrected,
   output logic temp_high_gain,
   input wire logic [3:0] trim_x_fine,
   input wire logic [4:0] trim_gain_xy,
   input wire logic trim_variant,
   input wire logic trim_parity,
   input wire logic queue_wr_valid,
   input wire logic [15:0] queue_wr_data
);
   // ----------------------------------------------------------------
   // Elaboration checks
   // ----------------------------------------------------------------
   if (DEPTH < 2 || DEPTH > 511)
   begin : g_bad_depth
      $error("DEPTH must lie between 2 and 511.");
   end
   if (PARITY_CYCLES < 16 || PARITY_CYCLES > 65535)
   begin : g_bad_period
      $error("PARITY_CYCLES must lie between 16 and 65535.");
   end

   localparam logic [8:0] DEPTH_W = 9'(DEPTH);
   localparam logic [15:0] PERIOD_LAST = 16'(PARITY_CYCLES - 1);

   aosr_pkg::aosr_state_t st_r;
   aosr_pkg::aosr_state_t st_nxt;
   logic [15:0] mem [DEPTH];
   logic [5:0] idx;
   logic access;
   logic done;
   logic mapped;
   logic push;
   logic pop;
   logic twelve_bit;
   logic low_noise;
   logic par_calc;
   logic check_start;
   logic [20:0] product;
   logic [15:0] word;
   logic [7:0] rbyte;

   assign idx = paddr[7:2];
   assign access = psel && penable;
   assign done = access && st_r.bus == aosr_pkg::BUS_DONE;

   // Mode decoding used by the data path.
   always_comb
   begin
      twelve_bit = 1'b0;
      low_noise = 1'b0;
      case (st_r.operating_mode_register[3:0])
         aosr_pkg::MODE_HEART_SOUND,
         aosr_pkg::MODE_ULTRA_LOW_POWER,
         aosr_pkg::MODE_VERY_LOW_POWER: twelve_bit = 1'b1;
         aosr_pkg::MODE_HIGH_PERF,
         aosr_pkg::MODE_LOW_POWER,
         aosr_pkg::MODE_REDUCED_BW: low_noise = 1'b1;
         default: twelve_bit = 1'b0;
      endcase
   end

   // Trim product of the X sample and the unsigned fine trim.
   assign product = $signed(x_sample) * $signed({1'b0, st_r.x_trim});
   assign par_calc = ^{st_r.x_trim, st_r.gain_xy, st_r.variant};
   assign check_start = st_r.par_cfg[0] && st_r.timer == PERIOD_LAST;
   assign word = mem[st_r.rd_ptr];
   assign rbyte = st_r.byte_sel ? word[7:0] : word[15:8];

   // Queue push and pop decisions.
   assign push = queue_wr_valid && (st_r.count < DEPTH_W || pop);
   assign pop = done && !pwrite && idx == aosr_pkg::IDX_QUEUE_PORT
      && mapped && st_r.count != 9'h000 && st_r.byte_sel;

   // Address decode for the bus.
   always_comb
   begin
      case (idx)
         aosr_pkg::IDX_Z_LOW, aosr_pkg::IDX_TEMP_HIGH,
         aosr_pkg::IDX_TEMP_LOW_TRIM, aosr_pkg::IDX_QUEUE_PORT,
         aosr_pkg::IDX_COUNT_LOW, aosr_pkg::IDX_COUNT_HIGH,
         aosr_pkg::IDX_MISC_ZERO, aosr_pkg::IDX_OPERATING_MODE_REGISTER,
         aosr_pkg::IDX_TEMP_CFG, aosr_pkg::IDX_PARITY_CFG,
         aosr_pkg::IDX_INT_STATUS, aosr_pkg::IDX_INT_MASK:
            mapped = paddr[1:0] == 2'h0;
         default: mapped = 1'b0;
      endcase
   end

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb
   begin
      st_nxt = st_r;
      // Trim fuses and variant strap are resampled every cycle.
      st_nxt.x_trim = trim_x_fine;
      st_nxt.gain_xy = trim_gain_xy;
      st_nxt.variant = trim_variant;
      if (z_valid)
      begin
         st_nxt.z_low = z_sample[7:0];
         if (twelve_bit)
         begin
            st_nxt.z_low[3:0] = 4'h0;
         end
      end
      if (temp_valid)
      begin
         st_nxt.temp = temp_sample;
      end
      st_nxt.temp_high_gain = st_r.temp_cfg[0];
      // Trim correction only on the low-noise path without bitstream.
      if (x_valid)
      begin
         if (low_noise && !st_r.operating_mode_register[aosr_pkg::OPM_PDM_BIT])
         begin
            st_nxt.x_out = x_sample
               + {{2{product[20]}}, product[20:aosr_pkg::TRIM_SHIFT]};
         end
         else
         begin
            st_nxt.x_out = x_sample;
         end
      end
      // Periodic parity check timer runs only while checking is enabled.
      if (!st_r.par_cfg[0] || check_start)
      begin
         st_nxt.timer = 16'h0000;
      end
      else
      begin
         st_nxt.timer = st_r.timer + 16'h0001;
      end
      // Queue pointers and entry count.
      if (push)
      begin
         st_nxt.wr_ptr = st_r.wr_ptr == DEPTH_W - 9'h001 ? 9'h000
            : st_r.wr_ptr + 9'h001;
      end
      if (pop)
      begin
         st_nxt.rd_ptr = st_r.rd_ptr == DEPTH_W - 9'h001 ? 9'h000
            : st_r.rd_ptr + 9'h001;
      end
      st_nxt.count = st_r.count + {8'h00, push} - {8'h00, pop};
      // Bus answer: one wait cycle, then data from a register.
      st_nxt.bus = aosr_pkg::BUS_IDLE;
      if (access && st_r.bus == aosr_pkg::BUS_IDLE)
      begin
         st_nxt.bus = aosr_pkg::BUS_DONE;
         st_nxt.pslverr = !mapped;
         st_nxt.prdata = 32'h0000_0000;
         if (mapped && !pwrite)
         begin
            case (idx)
               aosr_pkg::IDX_Z_LOW: st_nxt.prdata[7:0] = st_r.z_low;
               aosr_pkg::IDX_TEMP_HIGH:
                  st_nxt.prdata[7:0] = st_r.temp[11:4];
               aosr_pkg::IDX_TEMP_LOW_TRIM:
                  st_nxt.prdata[7:0] = {st_r.temp[3:0], st_r.x_trim};
               aosr_pkg::IDX_QUEUE_PORT:
                  st_nxt.prdata[7:0] = st_r.count != 9'h000 ? rbyte
                     : aosr_pkg::RESET_BYTE;
               aosr_pkg::IDX_COUNT_LOW:
                  st_nxt.prdata[7:0] = st_r.count[7:0];
               aosr_pkg::IDX_COUNT_HIGH:
                  st_nxt.prdata[0] = st_r.count[8];
               aosr_pkg::IDX_MISC_ZERO:
                  st_nxt.prdata[7:0] = {st_r.variant, st_r.par_check_flag,
                     st_r.par_err_flag, st_r.gain_xy};
               aosr_pkg::IDX_OPERATING_MODE_REGISTER: st_nxt.prdata[7:0] = st_r.operating_mode_register;
               aosr_pkg::IDX_TEMP_CFG: st_nxt.prdata[7:0] = st_r.temp_cfg;
               aosr_pkg::IDX_PARITY_CFG: st_nxt.prdata[7:0] = st_r.par_cfg;
               aosr_pkg::IDX_INT_STATUS: st_nxt.prdata[1:0] = st_r.int_stat;
               aosr_pkg::IDX_INT_MASK: st_nxt.prdata[1:0] = st_r.int_mask;
               default: st_nxt.prdata = 32'h0000_0000;
            endcase
         end
      end
      // Effects of a completed transfer.
      if (done && mapped)
      begin
         if (pwrite)
         begin
            // Any register write clears both parity flags.
            st_nxt.par_check_flag = 1'b0;
            st_nxt.par_err_flag = 1'b0;
            case (idx)
               aosr_pkg::IDX_OPERATING_MODE_REGISTER: st_nxt.operating_mode_register = pwdata[7:0];
               aosr_pkg::IDX_TEMP_CFG: st_nxt.temp_cfg = {7'h00, pwdata[0]};
               aosr_pkg::IDX_PARITY_CFG: st_nxt.par_cfg = {7'h00, pwdata[0]};
               aosr_pkg::IDX_INT_MASK: st_nxt.int_mask = pwdata[1:0];
               default: st_nxt.operating_mode_register = st_r.operating_mode_register;
            endcase
         end
         else if (idx == aosr_pkg::IDX_INT_STATUS)
         begin
            st_nxt.int_stat = 2'h0;
         end
         else if (idx == aosr_pkg::IDX_QUEUE_PORT && st_r.count != 9'h000)
         begin
            st_nxt.byte_sel = !st_r.byte_sel;
         end
      end
      // Flag setting comes last so that a set wins over a clear.
      if (par_calc != trim_parity)
      begin
         st_nxt.par_err_flag = 1'b1;
      end
      if (check_start && par_calc != trim_parity)
      begin
         st_nxt.par_check_flag = 1'b1;
         st_nxt.int_stat[aosr_pkg::INT_PARITY_BIT] = 1'b1;
      end
      if (queue_wr_valid && !push)
      begin
         st_nxt.int_stat[aosr_pkg::INT_OVERFLOW_BIT] = 1'b1;
      end
      st_nxt.irq = |(st_nxt.int_stat & st_nxt.int_mask);
   end

   // ----------------------------------------------------------------
   // State register and sample memory
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk)
   begin
      if (!rstn)
      begin
         st_r <= '0;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   // Sample memory written from the queue write side.
   always_ff @(posedge sys_clk)
   begin
      if (push)
      begin
         mem[st_r.wr_ptr] <= queue_wr_data;
      end
   end

   assign prdata = st_r.prdata;
   assign pready = st_r.bus == aosr_pkg::BUS_DONE;
   assign pslverr = st_r.pslverr;
   assign irq = st_r.irq;
   assign x_corrected = st_r.x_out;
   assign temp_high_gain = st_r.temp_high_gain;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   sequence s_rd_setup(logic [5:0] i);
      psel && !penable && !pwrite && idx == i;
   endsequence
   sequence s_rd_answer;
      psel && penable ##1 pready;
   endsequence

   property p_low_nibble;
      @(posedge sys_clk) disable iff (!rstn)
      z_valid && twelve_bit |=> st_r.z_low[3:0] == 4'h0;
   endproperty
   a_low_nibble: assert property (p_low_nibble)
      else $error("Low nibble not forced in twelve-bit mode.");

   property p_trim_applied;
      @(posedge sys_clk) disable iff (!rstn)
      x_valid && low_noise && !st_r.operating_mode_register[5] && x_sample == 16'h0100
      && st_r.x_trim == 4'h3 |=> x_corrected == 16'h0106;
   endproperty
   a_trim_applied: assert property (p_trim_applied)
      else $error("Trim correction value wrong.");

   property p_pdm_bypass;
      @(posedge sys_clk) disable iff (!rstn)
      x_valid && st_r.operating_mode_register[5] |=> x_corrected == $past(x_sample);
   endproperty
   a_pdm_bypass: assert property (p_pdm_bypass)
      else $error("Trim applied while bitstream output is on.");

   property p_count_read;
      @(posedge sys_clk) disable iff (!rstn)
      s_rd_setup(aosr_pkg::IDX_COUNT_HIGH) ##1 s_rd_answer
      |-> prdata == {31'h0, $past(st_r.count[8])};
   endproperty
   a_count_read: assert property (p_count_read)
      else $error("Entry count high bit misreported.");

   property p_count_step;
      @(posedge sys_clk) disable iff (!rstn)
      push && !pop |=> st_r.count == $past(st_r.count) + 9'h001;
   endproperty
   a_count_step: assert property (p_count_step)
      else $error("Entry count did not follow a write.");

   property p_err_sticky;
      @(posedge sys_clk) disable iff (!rstn)
      st_r.par_err_flag && !(done && pwrite && mapped)
      |=> st_r.par_err_flag;
   endproperty
   a_err_sticky: assert property (p_err_sticky)
      else $error("Parity flag dropped without a write.");

   property p_check_period;
      @(posedge sys_clk) disable iff (!rstn)
      check_start && st_r.par_cfg[0] ##1 st_r.par_cfg[0] [*8]
      |-> !check_start;
   endproperty
   a_check_period: assert property (p_check_period)
      else $error("Parity checks started too close together.");

   property p_misc_layout;
      @(posedge sys_clk) disable iff (!rstn)
      s_rd_setup(aosr_pkg::IDX_MISC_ZERO) ##1 s_rd_answer
      |-> prdata[7] == $past(st_r.variant)
      && prdata[4:0] == $past(st_r.gain_xy);
   endproperty
   a_misc_layout: assert property (p_misc_layout)
      else $error("Misc status layout wrong.");

   property p_byte_advance;
      @(posedge sys_clk) disable iff (!rstn)
      done && mapped && !pwrite && idx == aosr_pkg::IDX_QUEUE_PORT
      && st_r.count != 9'h000 |=> st_r.byte_sel != $past(st_r.byte_sel);
   endproperty
   a_byte_advance: assert property (p_byte_advance)
      else $error("Queue read position did not advance.");

   property p_gain_out;
      @(posedge sys_clk) disable iff (!rstn)
      $rose(st_r.temp_cfg[0]) |=> temp_high_gain;
   endproperty
   a_gain_out: assert property (p_gain_out)
      else $error("Temperature gain select not driven.");
endmodule : aosr_regs

// ===== testbench/aosr_host.sv
// APB host model that reads and writes the output and status registers.
`timescale 1ns/100ps
module aosr_host (
   input wire logic sys_clk,
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [7:0] paddr,
   output logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr
);
   // The bus rests idle until the first transfer.
   initial
   begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
   end
   // One transfer; the request holds until pready is seen high.
   task automatic xfer(input logic wr, input logic [7:0] a,
      input logic [31:0] wd, output logic [31:0] rd, output logic err);
      int n;
      n = 0;
      @(posedge sys_clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge sys_clk);
      penable <= 1'b1;
      do
      begin
         @(posedge sys_clk);
         n++;
      end
      while (pready !== 1'b1 && n < 16);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 16)
         accel_output_status_regs_tb.stop_wait();
   endtask : xfer
   // Host side trim correction for bitstream data.
   function automatic logic [15:0] trim_fix(input logic [15:0] x,
      input logic [3:0] t);
      logic signed [20:0] p;
      p = ($signed(x) * $signed({1'b0, t})) >>> 7;
      return x + p[15:0];
   endfunction : trim_fix
endmodule : aosr_host

// ===== testbench/accel_output_status_regs_tb.sv
// Self-checking bench for the output and status registers.
`timescale 1ns/100ps
module accel_output_status_regs_tb;
   logic sys_clk, rstn, psel, penable, pwrite, pready, pslverr, irq;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, d;
   logic z_valid, temp_valid, x_valid, temp_high_gain, trim_variant, e;
   logic trim_parity, queue_wr_valid;
   logic [15:0] z_sample, x_sample, x_corrected, queue_wr_data;
   logic [11:0] temp_sample;
   logic [3:0] trim_x_fine;
   logic [4:0] trim_gain_xy;
   int n_mismatch, cmp_count;
   logic [3:0] zm [4] = '{aosr_pkg::MODE_HIGH_PERF,
      aosr_pkg::MODE_HEART_SOUND, aosr_pkg::MODE_ULTRA_LOW_POWER,
      aosr_pkg::MODE_VERY_LOW_POWER};
   logic [7:0] zx [4] = '{8'h34, 8'h30, 8'h30, 8'h30};
   logic [3:0] xm [3] = '{aosr_pkg::MODE_LOW_POWER,
      aosr_pkg::MODE_REDUCED_BW, aosr_pkg::MODE_HIGH_PERF};
   logic [15:0] xs [3] = '{16'h0100, 16'hff00, 16'h0100};
   logic [15:0] xe [3] = '{16'h0106, 16'hfefa, 16'h0106};
   // ----------------------------------------------------------------
   // Design, host model and clock
   // ----------------------------------------------------------------
   aosr_regs #(.DEPTH(320), .PARITY_CYCLES(20)) dut (
      .sys_clk(sys_clk), .rstn(rstn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .irq(irq),
      .z_valid(z_valid), .z_sample(z_sample), .temp_valid(temp_valid),
      .temp_sample(temp_sample), .x_valid(x_valid), .x_sample(x_sample),
      .x_corrected(x_corrected), .temp_high_gain(temp_high_gain),
      .trim_x_fine(trim_x_fine), .trim_gain_xy(trim_gain_xy),
      .trim_variant(trim_variant), .trim_parity(trim_parity),
      .queue_wr_valid(queue_wr_valid), .queue_wr_data(queue_wr_data));
   aosr_host host (.sys_clk(sys_clk), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr));
   // Free running 20 MHz clock.
   always #25 sys_clk = ~sys_clk;
   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   // Prints the counts and the verdict, then ends the run.
   task summarize;
      $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : summarize
   // A wait that ran out of its bound ends the run as a mismatch.
   task stop_wait;
      n_mismatch++;
      summarize();
   endtask : stop_wait
   // Compares one value and reports a difference at once.
   task chk(input string nm, input logic [31:0] ex, input logic [31:0] g);
      cmp_count++;
      if (g !== ex)
      begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", nm, ex, g);
      end
   endtask : chk
   // Reads one register and checks data and error response.
   task rd(input logic [7:0] a, input logic [7:0] ex, input logic er = 0);
      host.xfer(1'b0, a, 32'h0, d, e);
      chk($sformatf("data at %h", a), {24'h0, ex}, d);
      chk($sformatf("error at %h", a), {31'h0, er}, {31'h0, e});
   endtask : rd
   // Writes one register; every write here is accepted.
   task wr(input logic [7:0] a, input logic [7:0] v);
      host.xfer(1'b1, a, {24'h0, v}, d, e);
      chk("write error", 32'h0, {31'h0, e});
   endtask : wr
   task tick(input int n);
      repeat (n) @(posedge sys_clk);
   endtask : tick
   // Sends one X sample and lets the corrected value settle.
   task xpulse(input logic [15:0] v);
      @(posedge sys_clk);
      x_valid <= 1'b1;
      x_sample <= v;
      @(posedge sys_clk);
      x_valid <= 1'b0;
      tick(3);
   endtask : xpulse
   // Pushes n back to back words counting up from base.
   task push(input int n, input logic [15:0] base);
      for (int i = 0; i < n; i++)
      begin
         @(posedge sys_clk);
         queue_wr_valid <= 1'b1;
         queue_wr_data <= base + 16'(i);
      end
      @(posedge sys_clk);
      queue_wr_valid <= 1'b0;
      tick(2);
   endtask : push
   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial
   begin
      {sys_clk, rstn, z_valid, temp_valid, x_valid, queue_wr_valid} = '0;
      {z_sample, x_sample, queue_wr_data, temp_sample} = '0;
      trim_x_fine = 4'h3;
      trim_gain_xy = 5'h04;
      trim_variant = 1'b1;
      trim_parity = 1'b0;
      n_mismatch = 0;
      cmp_count = 0;
      tick(2);
      rstn <= 1'b1;
      tick(2);
      rd(8'h68, 8'h00);
      rd(8'h6c, 8'h00);
      rd(8'h70, 8'h03);
      rd(8'h74, 8'h00);
      rd(8'h78, 8'h00);
      rd(8'h7c, 8'h00);
      rd(8'h80, 8'h84);
      rd(8'h04, 8'h00, 1'b1);
      rd(8'h69, 8'h00, 1'b1);
      wr(8'h68, 8'hff);
      $display("test reset and map done");
      for (int i = 0; i < 4; i++)
      begin
         wr(8'h98, {4'h0, zm[i]});
         @(posedge sys_clk);
         z_valid <= 1'b1;
         z_sample <= 16'h1234;
         @(posedge sys_clk);
         z_valid <= 1'b0;
         rd(8'h68, zx[i]);
      end
      $display("test z capture done");
      @(posedge sys_clk);
      temp_valid <= 1'b1;
      temp_sample <= 12'habc;
      @(posedge sys_clk);
      temp_valid <= 1'b0;
      rd(8'h6c, 8'hab);
      rd(8'h70, 8'hc3);
      wr(8'hc0, 8'h01);
      tick(2);
      chk("gain select", 32'h1, {31'h0, temp_high_gain});
      $display("test temperature done");
      for (int i = 0; i < 3; i++)
      begin
         wr(8'h98, {4'h0, xm[i]});
         xpulse(xs[i]);
         chk("x trim", {16'h0, xe[i]}, {16'h0, x_corrected});
      end
      wr(8'h98, 8'h2c);
      xpulse(16'h0100);
      chk("x bypass", 32'h0100, {16'h0, x_corrected});
      d = {16'h0, host.trim_fix(x_corrected, trim_x_fine)};
      chk("host fix", 32'h0106, d);
      $display("test trim done");
      push(2, 16'hbeef);
      host.xfer(1'b0, 8'h78, 32'h0, d, e);
      chk("count", 32'h2, d);
      for (int i = 0; i < 2 && i < d; i++)
      begin
         rd(8'h74, 8'hbe);
         rd(8'h74, 8'hef + 8'(i));
      end
      rd(8'h74, 8'h00);
      rd(8'h78, 8'h00);
      push(321, 16'h0);
      rd(8'h78, 8'h40);
      rd(8'h7c, 8'h01);
      chk("irq masked", 32'h0, {31'h0, irq});
      wr(8'hcc, 8'h02);
      tick(2);
      chk("irq overflow", 32'h1, {31'h0, irq});
      rd(8'hc8, 8'h02);
      tick(2);
      chk("irq cleared", 32'h0, {31'h0, irq});
      rd(8'hc8, 8'h00);
      $display("test queue done");
      @(posedge sys_clk);
      trim_parity <= 1'b1;
      tick(3);
      rd(8'h80, 8'ha4);
      wr(8'hcc, 8'h01);
      wr(8'hc4, 8'h01);
      tick(30);
      rd(8'h80, 8'he4);
      chk("irq parity", 32'h1, {31'h0, irq});
      @(posedge sys_clk);
      trim_parity <= 1'b0;
      tick(3);
      rd(8'h80, 8'he4);
      wr(8'hc4, 8'h00);
      rd(8'h80, 8'h84);
      rd(8'hc8, 8'h01);
      tick(2);
      chk("irq parity clear", 32'h0, {31'h0, irq});
      $display("test parity done");
      summarize();
   end
endmodule : accel_output_status_regs_tb
